// ---- logic/xdt_defines.svh ----
`ifndef XDT_DEFINES_SVH
`define XDT_DEFINES_SVH
// register offsets on the plain port
`define XDT_ADDR_STATUS 4'h0
`define XDT_ADDR_CTRL 4'h1
`define XDT_ADDR_SVA 4'h2
`define XDT_ADDR_IRQ_STAT 4'h3
`define XDT_ADDR_IRQ_CLR 4'h4
`define XDT_ADDR_IRQ_EN 4'h5
// status register bit positions
`define XDT_ST_DIR 3
`define XDT_ST_COI 4
`define XDT_ST_EXC 5
`define XDT_ST_ALD 6
`define XDT_ST_MSTS 7
// control register bit positions
`define XDT_CT_ENABLE 0
`define XDT_CT_EXIT 1
`define XDT_CT_WREL 2
// interrupt bit positions
`define XDT_IRQ_START 0
`define XDT_IRQ_STOP 1
`define XDT_IRQ_ADDR 2
`define XDT_IRQ_ALD 3
// reset value and per-byte bit counts
`define XDT_SVA_RST 7'h00
`define XDT_BYTE_BITS 4'h8
`define XDT_ACK_BIT 4'h9
`endif

// ---- logic/xdt_pkg.sv ----
package xdt_pkg;
  typedef enum logic [1:0] {
    XDT_IDLE = 2'b00,
    XDT_ADDR = 2'b01,
    XDT_DATA = 2'b10
  } xdt_phase_t;
  typedef logic [3:0] xdt_addr_t;
  typedef logic [7:0] xdt_data_t;
endpackage : xdt_pkg

// ---- logic/xdt_sync.sv ----
`timescale 1ns/1ps
// two flip-flop synchroniser, one per pin bit
module xdt_sync #(
  parameter int W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_r <= '1;
      o_q <= '1;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule : xdt_sync

// ---- logic/xdt_tracker.sv ----
`timescale 1ns/1ps
`include "xdt_defines.svh"
// Overview of operation
// - direction flag 0: receive, serial data output released to high impedance.
// - flag 1: drive shift-out latch, only after falling ninth clock of byte one.
// - stop condition or communication-exit write clears the flag, both roles.
// - reset or enable falling from 1 to 0 forces the flag to 0.
// - writing 1 to stretch-release clears the flag.
// - arbitration-lost flag rising clears the flag.
// - flag held 0 while master-state, extension, address-match flags and start generation are 0.
// - master sets the flag when it generates a start condition.
// - master keeps the flag set when sending direction bit 0.
// - master clears the flag when sending direction bit 1.
// - slave sets the flag when the master sends direction bit 1.
// - slave clears the flag on start detect or direction bit 0.
// - address-match sets at eighth rising clock when address equals own address.
// - extension flag sets at eighth rising clock when upper nibble 0000 or 1111.
module xdt_tracker (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire xdt_pkg::xdt_addr_t i_addr,
  input wire xdt_pkg::xdt_data_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output xdt_pkg::xdt_data_t o_rdata,
  output logic o_irq,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_master_state,
  input wire logic i_start_gen,
  input wire logic i_arb_lost,
  input wire logic i_shift_out_latch,
  output logic o_sda_out,
  output logic o_sda_oe
);
  import xdt_pkg::*;

  logic scl_s;
  logic sda_s;
  xdt_sync #(.W(2)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_d({i_scl, i_sda}),
    .o_q({scl_s, sda_s})
  );

  // bus edge and condition detection on synchronised levels
  logic scl_d_r, sda_d_r;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // state registers
  xdt_phase_t phase_r, phase_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [7:0] shreg_r, shreg_nxt;
  logic dir_r, dir_nxt;
  logic coi_r, coi_nxt;
  logic exc_r, exc_nxt;
  logic ald_r, ald_nxt;
  logic ald_in_r;
  logic drive_ok_r, drive_ok_nxt;
  logic en_r, en_nxt;
  logic [6:0] sva_r, sva_nxt;
  logic [3:0] ist_r, ist_nxt;
  logic [3:0] ien_r, ien_nxt;
  logic [7:0] rdata_nxt;
  logic irq_nxt;
  logic sda_out_nxt, sda_oe_nxt;

  logic wr_ctrl, exit_req, wrel_req, en_fall, ald_rise;
  assign wr_ctrl = i_wr && (i_addr == `XDT_ADDR_CTRL);
  assign exit_req = wr_ctrl && i_wdata[`XDT_CT_EXIT];
  assign wrel_req = wr_ctrl && i_wdata[`XDT_CT_WREL];
  assign en_fall = en_r && wr_ctrl && !i_wdata[`XDT_CT_ENABLE];
  assign ald_rise = i_arb_lost && !ald_in_r;

  logic [7:0] status_w;
  always_comb begin
    status_w = 8'h00;
    status_w[`XDT_ST_DIR] = dir_r;
    status_w[`XDT_ST_COI] = coi_r;
    status_w[`XDT_ST_EXC] = exc_r;
    status_w[`XDT_ST_ALD] = ald_r;
    status_w[`XDT_ST_MSTS] = i_master_state;
  end

  always_comb begin
    phase_nxt = phase_r;
    bitcnt_nxt = bitcnt_r;
    shreg_nxt = shreg_r;
    dir_nxt = dir_r;
    coi_nxt = coi_r;
    exc_nxt = exc_r;
    ald_nxt = ald_r;
    drive_ok_nxt = drive_ok_r;
    en_nxt = en_r;
    sva_nxt = sva_r;
    ist_nxt = ist_r;
    ien_nxt = ien_r;
    rdata_nxt = 8'h00;
    if (i_wr) begin
      case (i_addr)
        `XDT_ADDR_CTRL: en_nxt = i_wdata[`XDT_CT_ENABLE];
        `XDT_ADDR_SVA: sva_nxt = i_wdata[7:1];
        `XDT_ADDR_IRQ_CLR: ist_nxt = ist_r & ~i_wdata[3:0];
        `XDT_ADDR_IRQ_EN: ien_nxt = i_wdata[3:0];
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `XDT_ADDR_STATUS: begin
          rdata_nxt = status_w;
          ald_nxt = 1'b0;
        end
        `XDT_ADDR_CTRL: rdata_nxt = {7'h00, en_r};
        `XDT_ADDR_SVA: rdata_nxt = {sva_r, 1'b0};
        `XDT_ADDR_IRQ_STAT: rdata_nxt = {4'h0, ist_r};
        `XDT_ADDR_IRQ_EN: rdata_nxt = {4'h0, ien_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
    if (i_arb_lost && en_r) begin
      ald_nxt = 1'b1;
    end
    if (en_r) begin
      if (start_det) begin
        phase_nxt = XDT_ADDR;
        bitcnt_nxt = 4'hF; // the start's own scl fall wraps the count to zero
        coi_nxt = 1'b0;
        exc_nxt = 1'b0;
        drive_ok_nxt = 1'b0;
        ist_nxt[`XDT_IRQ_START] = 1'b1;
        dir_nxt = i_master_state ? dir_r : 1'b0;
      end else if (stop_det) begin
        phase_nxt = XDT_IDLE;
        coi_nxt = 1'b0;
        exc_nxt = 1'b0;
        drive_ok_nxt = 1'b0;
        dir_nxt = 1'b0;
        ist_nxt[`XDT_IRQ_STOP] = 1'b1;
      end else if (phase_r != XDT_IDLE) begin
        if (scl_rise) begin
          if (bitcnt_r < `XDT_BYTE_BITS) begin
            shreg_nxt = {shreg_r[6:0], sda_s};
          end
          if (phase_r == XDT_ADDR && bitcnt_r == 4'h7) begin
            // eighth rising clock: address byte complete
            if (shreg_r[6:0] == sva_r) begin
              coi_nxt = 1'b1;
            end
            if (shreg_r[6:3] == 4'h0 || shreg_r[6:3] == 4'hF) begin
              exc_nxt = 1'b1;
            end
            if (i_master_state) begin
              dir_nxt = ~sda_s;
            end else begin
              dir_nxt = sda_s;
            end
            ist_nxt[`XDT_IRQ_ADDR] = 1'b1;
          end
        end
        if (scl_fall) begin
          if (bitcnt_r == `XDT_ACK_BIT - 4'h1) begin
            bitcnt_nxt = 4'h0;
            phase_nxt = XDT_DATA;
            drive_ok_nxt = 1'b1;
          end else begin
            bitcnt_nxt = bitcnt_r + 4'h1;
          end
        end
      end
      if (i_start_gen) begin
        dir_nxt = 1'b1;
      end
    end
    if (ald_rise) begin
      ist_nxt[`XDT_IRQ_ALD] = 1'b1;
      dir_nxt = 1'b0;
    end
    if (wrel_req) begin
      dir_nxt = 1'b0;
    end
    if (exit_req) begin
      dir_nxt = 1'b0;
      coi_nxt = 1'b0;
      exc_nxt = 1'b0;
      phase_nxt = XDT_IDLE;
      drive_ok_nxt = 1'b0;
    end
    if (en_fall || !en_r) begin
      dir_nxt = 1'b0;
      coi_nxt = 1'b0;
      exc_nxt = 1'b0;
      ald_nxt = 1'b0;
      phase_nxt = XDT_IDLE;
      drive_ok_nxt = 1'b0;
    end
    // not taking part in a transfer: direction forced low
    if (!i_master_state && !exc_nxt && !coi_nxt && !i_start_gen) begin
      dir_nxt = 1'b0;
    end
    irq_nxt = |(ist_nxt & ien_nxt);
    // driving only while transmitting and past the first ack clock
    sda_oe_nxt = dir_nxt && drive_ok_nxt && !i_shift_out_latch;
    sda_out_nxt = 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_r <= XDT_IDLE;
      bitcnt_r <= 4'h0;
      shreg_r <= 8'h00;
      dir_r <= 1'b0;
      coi_r <= 1'b0;
      exc_r <= 1'b0;
      ald_r <= 1'b0;
      ald_in_r <= 1'b0;
      drive_ok_r <= 1'b0;
      en_r <= 1'b0;
      sva_r <= `XDT_SVA_RST;
      ist_r <= 4'h0;
      ien_r <= 4'h0;
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      bitcnt_r <= bitcnt_nxt;
      shreg_r <= shreg_nxt;
      dir_r <= dir_nxt;
      coi_r <= coi_nxt;
      exc_r <= exc_nxt;
      ald_r <= ald_nxt;
      ald_in_r <= i_arb_lost;
      drive_ok_r <= drive_ok_nxt;
      en_r <= en_nxt;
      sva_r <= sva_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      o_rdata <= rdata_nxt;
      o_irq <= irq_nxt;
      o_sda_out <= sda_out_nxt;
      o_sda_oe <= sda_oe_nxt;
    end
  end

  // bus clocks since start, counted apart from the shifter so the checks do not lean on it
  logic [3:0] rise_cnt_r, rise_cnt_nxt;
  logic ninth_fall_r, ninth_fall_nxt;
  always_comb begin
    rise_cnt_nxt = rise_cnt_r;
    ninth_fall_nxt = ninth_fall_r;
    if (start_det || stop_det) begin
      rise_cnt_nxt = 4'h0;
      ninth_fall_nxt = 1'b0;
    end else begin
      if (scl_rise && rise_cnt_r != `XDT_ACK_BIT) begin
        rise_cnt_nxt = rise_cnt_r + 4'h1;
      end
      if (scl_fall && rise_cnt_r == `XDT_ACK_BIT) begin
        ninth_fall_nxt = 1'b1;
      end
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rise_cnt_r <= 4'h0;
      ninth_fall_r <= 1'b0;
    end else begin
      rise_cnt_r <= rise_cnt_nxt;
      ninth_fall_r <= ninth_fall_nxt;
    end
  end

  // eighth rising clock of an address byte
  sequence s_eighth_rise;
    en_r && phase_r == XDT_ADDR && scl_rise && rise_cnt_r == `XDT_BYTE_BITS - 4'h1 && !start_det && !stop_det;
  endsequence
  // nothing that clears the direction flag in the same cycle
  sequence s_no_clear;
    !wrel_req && !exit_req && !ald_rise && !en_fall;
  endsequence

  // open-drain: released whenever receiving
  a_rx_released: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !dir_r |-> !o_sda_oe) else $error("data line driven while receiving");
  a_stop_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (en_r && stop_det && !i_start_gen) |=> !dir_r) else $error("direction not cleared by stop");
  a_exit_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (exit_req && !i_start_gen) |=> !dir_r) else $error("direction not cleared by exit");
  a_disable_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !en_r |=> !dir_r) else $error("direction set while disabled");
  a_wrel_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (wrel_req && !i_start_gen) |=> !dir_r) else $error("direction not cleared by release");
  a_ald_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (ald_rise && !i_start_gen) |=> !dir_r) else $error("direction not cleared by arbitration loss");
  a_idle_low: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (dir_r && !$past(i_start_gen)) |-> (coi_r || exc_r || $past(i_master_state)))
    else $error("direction set outside a transfer");
  a_start_sets: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (en_r && i_start_gen && !wrel_req && !exit_req && !ald_rise && !en_fall) |=> dir_r)
    else $error("start generation did not set direction");
  a_drive_late: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_sda_oe |-> ninth_fall_r) else $error("driving before ninth clock ends");
  // address byte decisions, taken at the eighth rising clock
  a_slave_tx_sets: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_eighth_rise ##0 (!i_master_state && sda_s && shreg_r[6:0] == sva_r) ##0 s_no_clear |=> dir_r)
    else $error("slave transmit bit did not set direction");
  a_slave_rx_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_eighth_rise ##0 (!i_master_state && !sda_s && !i_start_gen) |=> !dir_r)
    else $error("slave receive bit did not clear direction");
  a_slave_start_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (en_r && start_det && !i_master_state && !i_start_gen) |=> !dir_r)
    else $error("slave start detect did not clear direction");
  a_master_rd_clears: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_eighth_rise ##0 (i_master_state && sda_s && !i_start_gen) |=> !dir_r)
    else $error("master read bit did not clear direction");
  a_master_wr_keeps: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_eighth_rise ##0 (i_master_state && !sda_s) ##0 s_no_clear |=> dir_r)
    else $error("master write bit did not keep direction");
  a_match_sets: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_eighth_rise ##0 (shreg_r[6:0] == sva_r && !exit_req && !en_fall) |=> coi_r)
    else $error("address match not flagged");
  a_ext_sets: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_eighth_rise ##0 ((shreg_r[6:3] == 4'h0 || shreg_r[6:3] == 4'hF) && !exit_req && !en_fall) |=> exc_r)
    else $error("extension code not flagged");
  a_disable_releases: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !en_r |=> !o_sda_oe) else $error("data line driven while disabled");
endmodule : xdt_tracker

// ---- testbench/xdt_partner.sv ----
`timescale 1ns/1ps
// remote bus master; scl stands high between frames, sda only ever pulled low
module xdt_partner (
  output logic o_scl,
  output logic o_sda_low
);
  localparam time HALF = 80ns;
  initial begin
    o_scl = 1'h1;
    o_sda_low = 1'h0;
  end
  task automatic start();
    o_sda_low = 1'h1;
    #HALF o_scl = 1'h0;
  endtask : start
  // one 160 ns bit; data changes only while scl is low
  task automatic clk(input logic b);
    o_sda_low = ~b;
    #(HALF/2) o_scl = 1'h1;
    #HALF o_scl = 1'h0;
    #(HALF/2);
  endtask : clk
  task automatic stop();
    o_sda_low = 1'h1;
    #HALF o_scl = 1'h1;
    #HALF o_sda_low = 1'h0;
    #HALF;
  endtask : stop
endmodule : xdt_partner

// ---- testbench/xdt_tracker_test.sv ----
`timescale 1ns/1ps
`include "xdt_defines.svh"
module xdt_tracker_test;
  import xdt_pkg::*;
  localparam xdt_addr_t ST = `XDT_ADDR_STATUS;
  localparam xdt_addr_t CT = `XDT_ADDR_CTRL;
  logic i_ref_clk = 1'h0;
  logic i_nrst = 1'h0;
  xdt_addr_t i_addr = 4'h0;
  xdt_data_t i_wdata = 8'h00;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic i_master_state = 1'h0;
  logic i_start_gen = 1'h0;
  logic i_arb_lost = 1'h0;
  logic i_shift_out_latch = 1'h0;
  xdt_data_t o_rdata;
  xdt_data_t v;
  logic o_irq;
  logic o_sda_out;
  logic o_sda_oe;
  logic scl;
  logic sda_low;
  logic i_sda;
  int err_count = 0;
  int comparisons = 0;
  xdt_data_t a_tab[4] = '{8'h25, 8'hAB, 8'hAA, 8'hF1};
  xdt_data_t e_tab[4] = '{8'h00, 8'h18, 8'h10, 8'h28};
  // pulled-up line: low while either party pulls
  assign i_sda = ~(sda_low | o_sda_oe);
  always #10 i_ref_clk = ~i_ref_clk;
  xdt_partner p (.o_scl(scl), .o_sda_low(sda_low));
  xdt_tracker DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_scl(scl), .i_sda(i_sda),
    .i_master_state(i_master_state), .i_start_gen(i_start_gen), .i_arb_lost(i_arb_lost),
    .i_shift_out_latch(i_shift_out_latch), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe));
  task automatic chk(input xdt_data_t seen, input xdt_data_t exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input xdt_addr_t a, input xdt_data_t d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input xdt_addr_t a, input xdt_data_t m, input xdt_data_t e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    #1;
    chk(o_rdata & m, e);
  endtask : rd
  task automatic sgen();
    @(posedge i_ref_clk);
    i_start_gen <= 1'h1;
    @(posedge i_ref_clk);
    i_start_gen <= 1'h0;
    repeat (3) @(posedge i_ref_clk);
  endtask : sgen
  task automatic send8(input xdt_data_t b);
    for (int i = 7; i >= 0; i--) begin
      p.clk(b[i]);
    end
  endtask : send8
  task automatic test_done();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #1ms;
    err_count++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_nrst <= 1'h1;
    rd(ST, 8'hFF, 8'h00);
    wr(CT, 8'h01);
    wr(`XDT_ADDR_SVA, 8'hAA);
    wr(`XDT_ADDR_IRQ_EN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_ref_clk) i_shift_out_latch <= 1'h0;
      p.start();
      send8(a_tab[k]);
      rd(ST, 8'hFF, e_tab[k]);
      chk({7'h00, o_sda_oe}, 8'h00);
      p.clk(1'h1);
      repeat (4) @(negedge i_ref_clk);
      chk({7'h00, o_sda_oe}, {7'h00, e_tab[k][3]});
      chk({7'h00, o_sda_out}, 8'h00);
      @(posedge i_ref_clk) i_shift_out_latch <= 1'h1;
      repeat (4) @(negedge i_ref_clk);
      chk({7'h00, o_sda_oe}, 8'h00);
      p.stop();
      repeat (4) @(posedge i_ref_clk);
      rd(ST, 8'hFF, 8'h00);
    end
    chk({7'h00, o_irq}, 8'h01);
    rd(`XDT_ADDR_IRQ_STAT, 8'h0F, 8'h07);
    wr(`XDT_ADDR_IRQ_CLR, 8'h01);
    repeat (2) @(negedge i_ref_clk);
    // stop bit stays set but is masked, so the line must fall
    chk({7'h00, o_irq}, 8'h00);
    $display("test slave done");
    @(posedge i_ref_clk) i_master_state <= 1'h1;
    for (int k = 0; k < 2; k++) begin
      p.start();
      sgen();
      rd(ST, 8'hFF, 8'h88);
      send8(k ? 8'h61 : 8'h60);
      rd(ST, 8'hFF, k ? 8'h80 : 8'h88);
      p.clk(1'h1);
      p.stop();
      repeat (4) @(posedge i_ref_clk);
      rd(ST, 8'h08, 8'h00);
    end
    $display("test master done");
    for (int k = 0; k < 4; k++) begin
      sgen();
      rd(ST, 8'h08, 8'h08);
      case (k)
        0: wr(CT, 8'h03);
        1: wr(CT, 8'h05);
        2: @(posedge i_ref_clk) i_arb_lost <= 1'h1;
        default: wr(CT, 8'h00);
      endcase
      repeat (2) @(posedge i_ref_clk);
      rd(ST, 8'h08, 8'h00);
      @(posedge i_ref_clk) i_arb_lost <= 1'h0;
    end
    $display("test clears done");
    wr(CT, 8'h01);
    sgen();
    rd(ST, 8'h08, 8'h08);
    @(posedge i_ref_clk) i_master_state <= 1'h0;
    repeat (3) @(posedge i_ref_clk);
    rd(ST, 8'h08, 8'h00);
    wr(ST, 8'hFF);
    rd(ST, 8'hFF, 8'h00);
    rd(4'hF, 8'hFF, 8'h00);
    $display("test misc done");
    test_done();
  end
endmodule : xdt_tracker_test
